// ==== logic/ccp_cursor_regs.sv ====
// Purpose: double-buffered cursor position and colors 0/1 behind an APB slave
// Assumes: vblank and engine status come from logic on pclk, so no synchronisers
// Notes: pready is always high; reads return flop data, bad accesses raise pslverr
`timescale 1ns/1ns
module ccp_cursor_regs import ccp_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // display timing and status
  input wire logic vblank,
  input wire logic display_engine_running,
  // cursor state in effect
  output logic signed [15:0] cursor_x_now,
  output logic signed [15:0] cursor_y_now,
  output ccp_rgb_t first_color_now,
  output ccp_rgb_t second_color_now,
  output logic cursor_update_armed,
  // lookup table ports
  output ccp_rgb_t color_lookup_table_idx0,
  input ccp_rgb_t color_lookup_table_data0,
  output ccp_rgb_t color_lookup_table_idx1,
  input ccp_rgb_t color_lookup_table_data1,
  // shaped cursor pixels
  output ccp_rgb_t first_pixel,
  output ccp_rgb_t second_pixel
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  ccp_pos_t pos_hold_reg;
  ccp_pos_t pos_now_reg;
  ccp_rgb_t col0_hold_reg;
  ccp_rgb_t col0_now_reg;
  ccp_rgb_t col1_hold_reg;
  ccp_rgb_t col1_now_reg;
  logic armed_reg;
  ccp_mode_t mode_reg;
  logic lut_en_reg;
  logic [31:0] rdata_reg;
  logic err_reg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic wr_ph;
  logic wr_pos;
  logic wr_col0;
  logic wr_col1;
  logic wr_sts;
  logic wr_ctrl;
  logic addr_ok;
  logic addr_ro;
  logic [31:0] wmask;
  logic copy_now;

  // setup phase captures data; access phase commits writes
  assign setup_ph = psel && !penable;
  assign wr_ph = psel && penable && pwrite && !err_reg;

  // byte-lane mask from the strobes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{pstrb[i]}};
    end
  end

  // mapped and read-only address checks
  always_comb begin
    addr_ok = 1'b0;
    addr_ro = 1'b0;
    unique case (paddr)
      OFS_POS_HOLD, OFS_COL0_HOLD, OFS_COL1_HOLD, OFS_STATUS, OFS_CTRL: addr_ok = 1'b1;
      OFS_POS_NOW, OFS_COL0_NOW, OFS_COL1_NOW: begin
        addr_ok = 1'b1;
        addr_ro = 1'b1;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  // write strobes per register
  assign wr_pos = wr_ph && (paddr == OFS_POS_HOLD);
  assign wr_col0 = wr_ph && (paddr == OFS_COL0_HOLD);
  assign wr_col1 = wr_ph && (paddr == OFS_COL1_HOLD);
  assign wr_sts = wr_ph && (paddr == OFS_STATUS);
  assign wr_ctrl = wr_ph && (paddr == OFS_CTRL);

  // armed vblank while the engine runs moves held values into the active copies
  assign copy_now = vblank && armed_reg && display_engine_running;

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign prdata = rdata_reg;
  assign pslverr = psel && penable && err_reg;

  // error flag: unmapped, or write to a read-only word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 1'b0;
    end else if (setup_ph) begin
      err_reg <= !addr_ok || (pwrite && addr_ro);
    end
  end

  // read data latched in setup, reserved bits zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= RST_WORD;
    end else if (setup_ph) begin
      rdata_reg <= RST_WORD;
      if (!pwrite) begin
        unique case (paddr)
          OFS_POS_HOLD: rdata_reg <= pos_hold_reg;
          OFS_POS_NOW: rdata_reg <= pos_now_reg;
          OFS_COL0_HOLD: rdata_reg <= {8'h00, col0_hold_reg};
          OFS_COL0_NOW: rdata_reg <= {8'h00, col0_now_reg};
          OFS_COL1_HOLD: rdata_reg <= {8'h00, col1_hold_reg};
          OFS_COL1_NOW: rdata_reg <= {8'h00, col1_now_reg};
          OFS_STATUS: rdata_reg[STS_ARMED_BIT] <= armed_reg;
          OFS_CTRL: begin
            rdata_reg[CTRL_MODE_LSB +: 2] <= mode_reg;
            rdata_reg[CTRL_LUT_BIT] <= lut_en_reg;
          end
          default: rdata_reg <= RST_WORD;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // position copies
  // ----------------------------------------------------------------

  // holding position takes software writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_hold_reg <= RST_POS;
    end else if (wr_pos) begin
      pos_hold_reg <= (pos_hold_reg & ~wmask) | (pwdata & wmask);
    end
  end

  // active position: immediate when stopped, else at armed vblank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_now_reg <= RST_POS;
    end else if (wr_pos && !display_engine_running) begin
      pos_now_reg <= (pos_hold_reg & ~wmask) | (pwdata & wmask);
    end else if (copy_now) begin
      pos_now_reg <= pos_hold_reg;
    end
  end

  // ----------------------------------------------------------------
  // armed trigger
  // ----------------------------------------------------------------

  // position write while running sets; write-one or vblank copy clears; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_reg <= 1'b0;
    end else if (wr_pos && display_engine_running) begin
      armed_reg <= 1'b1;
    end else if (wr_sts && pstrb[3] && pwdata[STS_ARMED_BIT]) begin
      armed_reg <= 1'b0;
    end else if (copy_now) begin
      armed_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // color copies
  // ----------------------------------------------------------------

  // holding colors take software writes, top byte dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col0_hold_reg <= RST_RGB;
      col1_hold_reg <= RST_RGB;
    end else begin
      if (wr_col0) begin
        col0_hold_reg <= (col0_hold_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
      if (wr_col1) begin
        col1_hold_reg <= (col1_hold_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
      end
    end
  end

  // active color 0: bypass when stopped, else armed vblank copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col0_now_reg <= RST_RGB;
    end else if (wr_col0 && !display_engine_running) begin
      col0_now_reg <= (col0_hold_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
    end else if (copy_now) begin
      col0_now_reg <= col0_hold_reg;
    end
  end

  // active color 1: bypass when stopped, else armed vblank copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col1_now_reg <= RST_RGB;
    end else if (wr_col1 && !display_engine_running) begin
      col1_now_reg <= (col1_hold_reg & ~wmask[23:0]) | (pwdata[23:0] & wmask[23:0]);
    end else if (copy_now) begin
      col1_now_reg <= col1_hold_reg;
    end
  end

  // ----------------------------------------------------------------
  // display mode control
  // ----------------------------------------------------------------

  // pixel mode and lookup enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= CCP_MODE_24;
      lut_en_reg <= 1'b0;
    end else if (wr_ctrl && pstrb[0]) begin
      unique case (pwdata[CTRL_MODE_LSB +: 2])
        2'h1: mode_reg <= CCP_MODE_16;
        2'h2: mode_reg <= CCP_MODE_8;
        default: mode_reg <= CCP_MODE_24;
      endcase
      lut_en_reg <= pwdata[CTRL_LUT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // outputs in effect
  // ----------------------------------------------------------------
  assign cursor_x_now = pos_now_reg.x;
  assign cursor_y_now = pos_now_reg.y;
  assign first_color_now = col0_now_reg;
  assign second_color_now = col1_now_reg;
  assign cursor_update_armed = armed_reg;

  // ----------------------------------------------------------------
  // pixel shaping for both 2 bpp colors
  // ----------------------------------------------------------------

  // color 0 shaping
  ccp_color_fmt u_fmt0 (
    .pclk(pclk),
    .presetn(presetn),
    .color(col0_now_reg),
    .pixel_mode(mode_reg),
    .lut_enable(lut_en_reg),
    .lut_index(color_lookup_table_idx0),
    .lut_data(color_lookup_table_data0),
    .pixel(first_pixel)
  );

  // color 1 shaping
  ccp_color_fmt u_fmt1 (
    .pclk(pclk),
    .presetn(presetn),
    .color(col1_now_reg),
    .pixel_mode(mode_reg),
    .lut_enable(lut_en_reg),
    .lut_index(color_lookup_table_idx1),
    .lut_data(color_lookup_table_data1),
    .pixel(second_pixel)
  );

endmodule

// ==== logic/ccp_pkg.sv ====
// Purpose: shared constants and types for the cursor color and position registers
// Assumes: 32-bit APB data, byte addresses within a 12-bit window
// Notes: one word per register, reserved bits read as zero
package ccp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_POS_HOLD = 12'h090;
  localparam logic [ADDR_W-1:0] OFS_POS_NOW = 12'h094;
  localparam logic [ADDR_W-1:0] OFS_COL0_HOLD = 12'h098;
  localparam logic [ADDR_W-1:0] OFS_COL0_NOW = 12'h09c;
  localparam logic [ADDR_W-1:0] OFS_COL1_HOLD = 12'h0a0;
  localparam logic [ADDR_W-1:0] OFS_COL1_NOW = 12'h0a4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h0c0;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h0c4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_Y_LSB = 16;
  localparam int POS_X_LSB = 0;
  localparam int RED_LSB = 16;
  localparam int GREEN_LSB = 8;
  localparam int BLUE_LSB = 0;
  localparam int STS_ARMED_BIT = 31;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_LUT_BIT = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [4:0] MASK5 = 5'h1f;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } ccp_rgb_t;

  typedef struct packed {
    logic signed [15:0] y;
    logic signed [15:0] x;
  } ccp_pos_t;

  typedef enum logic [1:0] {
    CCP_MODE_24 = 2'h0,
    CCP_MODE_16 = 2'h1,
    CCP_MODE_8 = 2'h2
  } ccp_mode_t;

  localparam ccp_rgb_t RST_RGB = 24'h00_0000;
  localparam ccp_pos_t RST_POS = 32'h0000_0000;

endpackage

// ==== logic/ccp_color_fmt.sv ====
// Purpose: shapes one active cursor color into pixel data for the display path
// Assumes: lookup table sits outside and answers combinationally on lut_data
// Notes: output pixel is registered, one cycle behind its inputs
`timescale 1ns/1ns
module ccp_color_fmt import ccp_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // color and display mode
  input ccp_rgb_t color,
  input ccp_mode_t pixel_mode,
  input wire logic lut_enable,
  // lookup table port
  output ccp_rgb_t lut_index,
  input ccp_rgb_t lut_data,
  // shaped pixel
  output ccp_rgb_t pixel
);

  ccp_rgb_t raw;

  // narrow the channels per pixel mode
  always_comb begin
    raw = color;
    unique case (pixel_mode)
      CCP_MODE_16: begin
        raw.red = {3'h0, color.red[4:0]};
        raw.green = {2'h0, color.green[5:0]};
        raw.blue = {3'h0, color.blue[4:0] & MASK5};
      end
      CCP_MODE_8: begin
        raw = '{red: color.blue, green: color.blue, blue: color.blue};
      end
      default: raw = color;
    endcase
  end

  // same lookup path as ordinary pixels
  assign lut_index = raw;

  // registered pixel out, through the table when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel <= RST_RGB;
    end else begin
      pixel <= lut_enable ? lut_data : raw;
    end
  end

endmodule

// ==== testbench/ccp_cursor_regs_monitor.sv ====
// Purpose: checker for the cursor color and position registers
// Assumes: one pclk domain, full byte strobes on stopped-mode writes
// Notes: bound into every instance of the register bank
`timescale 1ns/1ns
module ccp_cursor_regs_monitor import ccp_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  // display side
  input wire logic vblank,
  input wire logic display_engine_running,
  input wire logic signed [15:0] cursor_x_now,
  input wire logic signed [15:0] cursor_y_now,
  input ccp_rgb_t first_color_now,
  input ccp_rgb_t second_color_now,
  input wire logic cursor_update_armed
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic run;
  logic full;
  // committed write, engine state, whole-word strobe
  assign wr = psel && penable && pwrite;
  assign run = display_engine_running;
  assign full = pstrb == 4'hf;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_pos_arms: assert property (wr && paddr == OFS_POS_HOLD && run |=> cursor_update_armed)
    else $error("position write left trigger clear");
  a_vblank_clears: assert property (cursor_update_armed && vblank && run && !wr
    |=> !cursor_update_armed)
    else $error("trigger stayed set after copy");
  a_armed_holds: assert property (cursor_update_armed && !vblank && !wr |=> cursor_update_armed)
    else $error("trigger dropped on its own");
  a_hold_only: assert property (wr && paddr == OFS_COL0_HOLD && run && !vblank
    |=> $stable(first_color_now))
    else $error("running color write reached active copy");
  a_idle_stable: assert property (!cursor_update_armed && !wr
    |=> $stable(first_color_now) && $stable(second_color_now) && $stable(cursor_x_now))
    else $error("active copy changed without trigger");
  a_stop_col0: assert property (wr && paddr == OFS_COL0_HOLD && !run && full
    |=> first_color_now == 24'($past(pwdata)))
    else $error("stopped color 0 write not immediate");
  a_stop_col1: assert property (wr && paddr == OFS_COL1_HOLD && !run && full
    |=> second_color_now == 24'($past(pwdata)))
    else $error("stopped color 1 write not immediate");
  a_stop_pos: assert property (wr && paddr == OFS_POS_HOLD && !run && full
    |=> {cursor_y_now, cursor_x_now} == $past(pwdata))
    else $error("stopped position write not immediate");
  a_ro_refused: assert property (wr && (paddr == OFS_POS_NOW || paddr == OFS_COL0_NOW)
    |-> pslverr)
    else $error("write to read-only word accepted");
  // main scenarios reached
  c_copy: cover property (cursor_update_armed && vblank && run);
  c_stopped: cover property (wr && !run);
  c_refused: cover property (wr && pslverr);
endmodule

bind ccp_cursor_regs ccp_cursor_regs_monitor i_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .vblank, .display_engine_running,
  .cursor_x_now, .cursor_y_now, .first_color_now, .second_color_now, .cursor_update_armed);

// ==== testbench/ccp_cursor_regs_bench.sv ====
// Purpose: self-checking bench for the cursor color and position registers
// Assumes: zero-wait apb slave on pclk
// Notes: lookup table answers with its index xor a fixed mask
`timescale 1ns/1ns
module ccp_cursor_regs_bench import ccp_pkg::*;;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  localparam ccp_rgb_t LUT_MASK = 24'h5a_5a5a;
  logic pclk, presetn, psel, penable, pwrite, vblank, run, pready, pslverr, armed, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb;
  logic signed [15:0] cx, cy;
  ccp_rgb_t c0, c1, li0, li1, p0, p1;
  int num_errors, n_checks;
  ccp_cursor_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .vblank(vblank), .display_engine_running(run),
    .cursor_x_now(cx), .cursor_y_now(cy), .first_color_now(c0), .second_color_now(c1),
    .cursor_update_armed(armed), .color_lookup_table_idx0(li0),
    .color_lookup_table_data0(li0 ^ LUT_MASK), .color_lookup_table_idx1(li1),
    .color_lookup_table_data1(li1 ^ LUT_MASK), .first_pixel(p0), .second_pixel(p1));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // one-cycle vertical blank
  task automatic blank;
    @(posedge pclk);
    vblank <= 1'b1;
    @(posedge pclk);
    vblank <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [ADDR_W-1:0] ofs[5] = '{OFS_POS_NOW, OFS_COL0_HOLD, OFS_COL0_NOW, OFS_COL1_HOLD,
      OFS_COL1_NOW};
    foreach (ofs[i]) rd(ofs[i], 32'h0);
  endtask
  task automatic t_stopped;
    run <= 1'b0;
    apb(1'b1, OFS_COL0_HOLD, 32'hffa1_b2c3);
    apb(1'b1, OFS_COL1_HOLD, 32'h0012_3456);
    apb(1'b1, OFS_POS_HOLD, 32'h8000_fff0);
    rd(OFS_COL0_HOLD, 32'h00a1_b2c3);
    rd(OFS_COL0_NOW, 32'h00a1_b2c3);
    rd(OFS_COL1_NOW, 32'h0012_3456);
    rd(OFS_POS_NOW, 32'h8000_fff0);
    chk(32'(cx), 32'hffff_fff0);
    chk(32'(cy), 32'hffff_8000);
    chk({31'h0, armed}, 32'h0);
  endtask
  task automatic t_buffer;
    run <= 1'b1;
    apb(1'b1, OFS_COL0_HOLD, 32'h0011_2233);
    apb(1'b1, OFS_COL1_HOLD, 32'h0077_8899);
    rd(OFS_COL0_NOW, 32'h00a1_b2c3);
    rd(OFS_COL1_NOW, 32'h0012_3456);
    blank();
    rd(OFS_COL0_NOW, 32'h00a1_b2c3);
    apb(1'b1, OFS_POS_HOLD, 32'h0005_0007);
    rd(OFS_STATUS, 32'h8000_0000);
    blank();
    rd(OFS_COL0_NOW, 32'h0011_2233);
    rd(OFS_COL1_NOW, 32'h0077_8899);
    chk({8'h0, c1}, 32'h0077_8899);
    rd(OFS_POS_NOW, 32'h0005_0007);
    chk({31'h0, armed}, 32'h0);
  endtask
  task automatic t_cancel;
    apb(1'b1, OFS_COL0_HOLD, 32'h0044_5566);
    apb(1'b1, OFS_POS_HOLD, 32'h0001_0001);
    apb(1'b1, OFS_STATUS, 32'h8000_0000);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_POS_HOLD, 32'h0001_0001);
    blank();
    rd(OFS_COL0_NOW, 32'h0011_2233);
  endtask
  task automatic t_refuse;
    apb(1'b1, OFS_POS_NOW, 32'h1234_5678);
    chk({31'h0, err}, 32'h1);
    rd(OFS_POS_NOW, 32'h0005_0007);
    apb(1'b1, OFS_COL0_NOW, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask
  // 24-bit, 16-bit, 8-bit, lookup enabled, then unused mode code with lookup
  task automatic t_modes;
    logic [31:0] ctl[5] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h7};
    logic [31:0] pix[5] = '{32'ha5_c37e, 32'h05_031e, 32'h7e_7e7e, 32'hff_9924, 32'hff_9924};
    logic [31:0] pix1[5] = '{32'h77_8899, 32'h17_0819, 32'h99_9999, 32'h2d_d2c3, 32'h2d_d2c3};
    logic [31:0] idx[5] = '{32'ha5_c37e, 32'h05_031e, 32'h7e_7e7e, 32'ha5_c37e, 32'ha5_c37e};
    run <= 1'b0;
    apb(1'b1, OFS_COL0_HOLD, 32'h00a5_c37e);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_CTRL, ctl[i]);
      repeat (2) @(posedge pclk);
      #1;
      chk({8'h0, p0}, pix[i]);
      chk({8'h0, p1}, pix1[i]);
      chk({8'h0, li0}, idx[i]);
    end
    rd(OFS_CTRL, 32'h4);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, vblank, run} = 6'h0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stopped();
    t_buffer();
    t_cancel();
    t_refuse();
    t_modes();
    summarize();
  end
  initial begin
    #20000;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
endmodule
